// *** design/dbf_pkg.sv ***
// Constants, types and register map for the dual-band complex frame assembler
package dbf_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DBF_REG_CTRL = 8'h00;
    localparam logic [7:0] DBF_REG_STAT = 8'h04;
    localparam logic [7:0] DBF_REG_FRAMES = 8'h08;
    localparam logic [7:0] DBF_REG_MODE = 8'h0C;

    localparam int DBF_CTRL_EN_BIT = 0;
    localparam int DBF_CTRL_FMT_BIT = 1;
    localparam int DBF_CTRL_DEC_LSB = 8;
    localparam int DBF_CTRL_DEC_W = 6;
    localparam logic [31:0] DBF_CTRL_RST = 32'h0000_0800;

    localparam int DBF_STAT_CFG_OK_BIT = 0;
    localparam int DBF_STAT_RUN_BIT = 1;
    localparam int DBF_STAT_UNDERRUN_BIT = 2;
    localparam int DBF_STAT_FMT_BIT = 3;

    localparam int DBF_MODE_LOW_LSB = 0;
    localparam int DBF_MODE_MID_LSB = 2;
    localparam int DBF_MODE_HIGH_LSB = 4;
    localparam int DBF_MODE_PLL40_BIT = 6;
    localparam int DBF_MODE_MULT_LSB = 8;

    // ------------------------------------------------------------
    // Formats, modes and rates
    // ------------------------------------------------------------
    typedef enum logic {
        DBF_FMT_8821 = 1'b0,
        DBF_FMT_4841 = 1'b1
    } dbf_fmt_t;

    typedef enum logic [1:0] {
        DBF_ST_IDLE = 2'b00,
        DBF_ST_RUN = 2'b01
    } dbf_state_t;

    localparam logic [1:0] DBF_OCT_LAST_8821 = 2'h1;
    localparam logic [1:0] DBF_OCT_LAST_4841 = 2'h3;

    localparam logic [5:0] DBF_PLL_MULT_20X = 6'h14;
    localparam logic [5:0] DBF_PLL_MULT_40X = 6'h28;

    localparam logic [1:0] DBF_SEL_LOW_8821 = 2'h1;
    localparam logic [1:0] DBF_SEL_LOW_4841 = 2'h2;
    localparam logic [1:0] DBF_SEL_MID = 2'h0;
    localparam logic [1:0] DBF_SEL_HIGH = 2'h0;

    localparam logic [5:0] DBF_DEC_8 = 6'h08;
    localparam logic [5:0] DBF_DEC_9 = 6'h09;
    localparam logic [5:0] DBF_DEC_10 = 6'h0A;
    localparam logic [5:0] DBF_DEC_12 = 6'h0C;
    localparam logic [5:0] DBF_DEC_16 = 6'h10;
    localparam logic [5:0] DBF_DEC_18 = 6'h12;
    localparam logic [5:0] DBF_DEC_20 = 6'h14;
    localparam logic [5:0] DBF_DEC_24 = 6'h18;
    localparam logic [5:0] DBF_DEC_32 = 6'h20;

endpackage

// *** design/dbf_mode_check.sv ***
// Format check and link setting lookup
`timescale 1ns/10ps
`default_nettype none
module dbf_mode_check
    import dbf_pkg::*;
(
    input wire dbf_fmt_t fmt_i,           // Requested lane format
    input wire logic [5:0] dec_i,         // Requested decimation factor
    output logic cfg_ok_o,                // Combination is supported
    output logic pll_40x_o,               // Serializer PLL at 40x
    output logic [5:0] pll_mult_o,        // Lane rate times decimation
    output logic [1:0] sel_low_o,         // Mode field, low
    output logic [1:0] sel_mid_o,         // Mode field, mid
    output logic [1:0] sel_high_o         // Mode field, high
);

    wire logic dec_common;
    wire logic dec_wide_only;
    wire logic is_4841;

    assign is_4841 = (fmt_i == DBF_FMT_4841);
    assign dec_common = (dec_i == DBF_DEC_8) || (dec_i == DBF_DEC_9)
        || (dec_i == DBF_DEC_10) || (dec_i == DBF_DEC_12)
        || (dec_i == DBF_DEC_16) || (dec_i == DBF_DEC_18)
        || (dec_i == DBF_DEC_20);
    assign dec_wide_only = (dec_i == DBF_DEC_24) || (dec_i == DBF_DEC_32);
    assign cfg_ok_o = dec_common || (dec_wide_only && is_4841);

    assign pll_40x_o = is_4841;
    // Lane Gbps per GSPS is this figure divided by the decimation
    assign pll_mult_o = is_4841 ? DBF_PLL_MULT_40X : DBF_PLL_MULT_20X;
    assign sel_low_o = is_4841 ? DBF_SEL_LOW_4841 : DBF_SEL_LOW_8821;
    assign sel_mid_o = DBF_SEL_MID;
    assign sel_high_o = DBF_SEL_HIGH;

endmodule
`default_nettype wire

// *** design/dbf_lane_mux.sv ***
// Octet selector for one lane of one channel
`timescale 1ns/10ps
`default_nettype none
module dbf_lane_mux
    import dbf_pkg::*;
#(
    parameter int LANE = 0
) (
    input wire dbf_fmt_t fmt_i,           // Active lane format
    input wire logic [1:0] oct_i,         // Octet index within frame
    input wire logic [15:0] b1_inph_i,    // Band 1 in-phase
    input wire logic [15:0] b1_quad_i,    // Band 1 quadrature
    input wire logic [15:0] b2_inph_i,    // Band 2 in-phase
    input wire logic [15:0] b2_quad_i,    // Band 2 quadrature
    output logic [7:0] octet_o,           // Selected octet
    output logic active_o                 // Lane carries data
);

    wire logic [1:0] smp_idx;
    wire logic [15:0] smp;
    wire logic wide;

    assign wide = (fmt_i == DBF_FMT_4841);
    // Four-lane: lane 1 band 1, lane 2 band 2
    assign smp_idx = !wide ? 2'(LANE)
        : (LANE == 2) ? {1'b1, oct_i[1]} : {1'b0, oct_i[1]};
    assign smp = (smp_idx == 2'h0) ? b1_inph_i
        : (smp_idx == 2'h1) ? b1_quad_i
        : (smp_idx == 2'h2) ? b2_inph_i : b2_quad_i;
    assign active_o = !wide || (LANE == 1) || (LANE == 2);
    // Upper byte on the even octet, lower on the odd
    assign octet_o = !active_o ? 8'h00
        : (oct_i[0] ? smp[7:0] : smp[15:8]);

endmodule
`default_nettype wire

// *** design/dbf_frame_assembly.sv ***
// Dual-band complex frame assembler with Wishbone register access
`timescale 1ns/10ps
`default_nettype none
module dbf_frame_assembly
    import dbf_pkg::*;
(
    input wire logic clk_i,                  // Sample-rate clock
    input wire logic rst_i,                  // Synchronous reset, high
    // Wishbone slave
    input wire logic wb_cyc_i,               // Bus cycle
    input wire logic wb_stb_i,               // Strobe
    input wire logic wb_we_i,                // Write enable
    input wire logic [7:0] wb_adr_i,         // Byte address
    input wire logic [3:0] wb_sel_i,         // Byte selects
    input wire logic [31:0] wb_dat_i,        // Write data
    output logic [31:0] wb_dat_o,            // Read data
    output logic wb_ack_o,                   // Acknowledge
    // Down-converter samples, one frame per handshake
    input wire logic [15:0] chan_a_b1_inph_i, // A band 1 I
    input wire logic [15:0] chan_a_b1_quad_i, // A band 1 Q
    input wire logic [15:0] chan_a_b2_inph_i, // A band 2 I
    input wire logic [15:0] chan_a_b2_quad_i, // A band 2 Q
    input wire logic [15:0] chan_b_b1_inph_i, // B band 1 I
    input wire logic [15:0] chan_b_b1_quad_i, // B band 1 Q
    input wire logic [15:0] chan_b_b2_inph_i, // B band 2 I
    input wire logic [15:0] chan_b_b2_quad_i, // B band 2 Q
    input wire logic frame_valid_i,          // Samples present
    output logic frame_ready_o,              // Samples taken this edge
    // Lane octets toward the serializer
    output logic [7:0] chan_a_lane_zero_o,   // Lane A0
    output logic [7:0] chan_a_lane_one_o,    // Lane A1
    output logic [7:0] chan_a_lane_two_o,    // Lane A2
    output logic [7:0] chan_a_lane_three_o,  // Lane A3
    output logic [7:0] chan_b_lane_zero_o,   // Lane B0
    output logic [7:0] chan_b_lane_one_o,    // Lane B1
    output logic [7:0] chan_b_lane_two_o,    // Lane B2
    output logic [7:0] chan_b_lane_three_o,  // Lane B3
    output logic [7:0] lane_active_o,        // Lane in use, A0 at bit 0
    output logic octet_valid_o,              // Octets carry samples
    output logic frame_start_o,              // First octet of a frame
    // Serializer and link configuration
    output logic pll_40x_o,                  // PLL at 40x, else 20x
    output logic [5:0] pll_mult_o,           // Lane rate ratio numerator
    output logic [1:0] link_format_sel_low_o, // Mode field, low
    output logic [1:0] link_format_sel_mid_o, // Mode field, mid
    output logic [1:0] link_format_sel_high_o // Mode field, high
);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic underrun;
    logic [31:0] frames;
    logic [31:0] rd_data;
    logic ack;

    wire logic bus_req;
    wire logic wr_fire;
    wire logic hit_ctrl;
    wire logic hit_stat;
    wire logic hit_frames;
    wire logic hit_mode;
    wire logic [31:0] byte_mask;
    wire logic [31:0] next_ctrl;
    wire logic clr_underrun;

    assign bus_req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge that also samples ack high
    assign wr_fire = bus_req && ack && wb_we_i;
    assign hit_ctrl = (wb_adr_i == DBF_REG_CTRL);
    assign hit_stat = (wb_adr_i == DBF_REG_STAT);
    assign hit_frames = (wb_adr_i == DBF_REG_FRAMES);
    assign hit_mode = (wb_adr_i == DBF_REG_MODE);
    assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign next_ctrl = (ctrl & ~byte_mask) | (wb_dat_i & byte_mask);
    assign clr_underrun = wr_fire && hit_stat && wb_sel_i[0]
        && wb_dat_i[DBF_STAT_UNDERRUN_BIT];

    // ------------------------------------------------------------
    // Configuration check
    // ------------------------------------------------------------
    wire dbf_fmt_t req_fmt;
    wire logic [5:0] req_dec;
    wire logic cfg_ok;
    wire logic chk_40x;
    wire logic [5:0] chk_mult;
    wire logic [1:0] chk_low;
    wire logic [1:0] chk_mid;
    wire logic [1:0] chk_high;

    assign req_fmt = dbf_fmt_t'(ctrl[DBF_CTRL_FMT_BIT]);
    assign req_dec = ctrl[DBF_CTRL_DEC_LSB +: DBF_CTRL_DEC_W];

    dbf_mode_check u_check (
        .fmt_i(req_fmt),
        .dec_i(req_dec),
        .cfg_ok_o(cfg_ok),
        .pll_40x_o(chk_40x),
        .pll_mult_o(chk_mult),
        .sel_low_o(chk_low),
        .sel_mid_o(chk_mid),
        .sel_high_o(chk_high)
    );

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    dbf_state_t state;
    dbf_fmt_t act_fmt;
    logic have;
    logic [1:0] oct;
    logic [15:0] hold_a [4];
    logic [15:0] hold_b [4];

    wire logic running;
    wire logic [1:0] oct_last;
    wire logic at_last;
    wire logic take;
    wire logic start_ok;

    assign running = (state == DBF_ST_RUN);
    assign start_ok = ctrl[DBF_CTRL_EN_BIT] && cfg_ok;
    assign oct_last = (act_fmt == DBF_FMT_4841)
        ? DBF_OCT_LAST_4841 : DBF_OCT_LAST_8821;
    assign at_last = (oct == oct_last);
    // A new frame enters only when none is held or on the closing octet, so frames never tear
    assign frame_ready_o = running && (!have || at_last);
    assign take = frame_valid_i && frame_ready_o;

    // ------------------------------------------------------------
    // Lane selection
    // ------------------------------------------------------------
    wire logic [7:0] oct_a [4];
    wire logic [7:0] oct_b [4];
    wire logic [3:0] act_a;
    wire logic [3:0] act_b;

    // Channel B samples never reach an A lane and the reverse
    for (genvar g = 0; g < 4; g++) begin : g_lane
        dbf_lane_mux #(.LANE(g)) u_mux_a (
            .fmt_i(act_fmt),
            .oct_i(oct),
            .b1_inph_i(hold_a[0]),
            .b1_quad_i(hold_a[1]),
            .b2_inph_i(hold_a[2]),
            .b2_quad_i(hold_a[3]),
            .octet_o(oct_a[g]),
            .active_o(act_a[g])
        );
        dbf_lane_mux #(.LANE(g)) u_mux_b (
            .fmt_i(act_fmt),
            .oct_i(oct),
            .b1_inph_i(hold_b[0]),
            .b1_quad_i(hold_b[1]),
            .b2_inph_i(hold_b[2]),
            .b2_quad_i(hold_b[3]),
            .octet_o(oct_b[g]),
            .active_o(act_b[g])
        );
    end

    // ------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------
    wire logic [31:0] stat_word;
    wire logic [31:0] mode_word;
    wire logic [31:0] next_rd;

    assign stat_word = {28'h0000000, logic'(act_fmt), underrun, running, cfg_ok};
    assign mode_word = {18'h00000, chk_mult, 1'b0, chk_40x,
                        chk_high, chk_mid, chk_low};
    // Unmapped addresses answer with zero and ignore writes
    assign next_rd = hit_ctrl ? ctrl
        : hit_stat ? stat_word
        : hit_frames ? frames
        : hit_mode ? mode_word : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rd_data <= 32'h0000_0000;
        end else begin
            ack <= bus_req && !ack;
            if (bus_req && !ack) begin
                rd_data <= next_rd;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= DBF_CTRL_RST;
        end else if (wr_fire && hit_ctrl) begin
            ctrl <= next_ctrl;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rd_data;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Format is frozen while running; a change applies on re-enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= DBF_ST_IDLE;
            act_fmt <= DBF_FMT_8821;
        end else begin
            unique case (state)
                DBF_ST_IDLE: begin
                    if (start_ok) begin
                        state <= DBF_ST_RUN;
                        act_fmt <= req_fmt;
                    end
                end
                DBF_ST_RUN: begin
                    if (!ctrl[DBF_CTRL_EN_BIT]) begin
                        state <= DBF_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !running) begin
            have <= 1'b0;
            oct <= 2'h0;
        end else if (have) begin
            oct <= at_last ? 2'h0 : oct + 2'h1;
            if (at_last) begin
                have <= take;
            end
        end else begin
            have <= take;
            oct <= 2'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (take) begin
            hold_a[0] <= chan_a_b1_inph_i;
            hold_a[1] <= chan_a_b1_quad_i;
            hold_a[2] <= chan_a_b2_inph_i;
            hold_a[3] <= chan_a_b2_quad_i;
            hold_b[0] <= chan_b_b1_inph_i;
            hold_b[1] <= chan_b_b1_quad_i;
            hold_b[2] <= chan_b_b2_inph_i;
            hold_b[3] <= chan_b_b2_quad_i;
        end
    end

    // Underrun: a frame closed with nothing waiting; set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            underrun <= 1'b0;
        end else if (running && have && at_last && !take) begin
            underrun <= 1'b1;
        end else if (clr_underrun) begin
            underrun <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frames <= 32'h0000_0000;
        end else if (running && have && at_last) begin
            frames <= frames + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Lane outputs
    // ------------------------------------------------------------
    logic [7:0] lane_a [4];
    logic [7:0] lane_b [4];
    logic [7:0] lane_act;
    logic oct_vld;
    logic frm_start;

    wire logic emit;

    assign emit = running && have;

    // Lanes without data in this format stay at zero and inactive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_act <= 8'h00;
            oct_vld <= 1'b0;
            frm_start <= 1'b0;
        end else begin
            lane_act <= running ? {act_b, act_a} : 8'h00;
            oct_vld <= emit;
            frm_start <= emit && (oct == 2'h0);
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_i || !emit) begin
                lane_a[i] <= 8'h00;
                lane_b[i] <= 8'h00;
            end else begin
                lane_a[i] <= oct_a[i];
                lane_b[i] <= oct_b[i];
            end
        end
    end

    assign chan_a_lane_zero_o = lane_a[0];
    assign chan_a_lane_one_o = lane_a[1];
    assign chan_a_lane_two_o = lane_a[2];
    assign chan_a_lane_three_o = lane_a[3];
    assign chan_b_lane_zero_o = lane_b[0];
    assign chan_b_lane_one_o = lane_b[1];
    assign chan_b_lane_two_o = lane_b[2];
    assign chan_b_lane_three_o = lane_b[3];
    assign lane_active_o = lane_act;
    assign octet_valid_o = oct_vld;
    assign frame_start_o = frm_start;

    // ------------------------------------------------------------
    // Link configuration, following the running format
    // ------------------------------------------------------------
    logic pll_40x;
    logic [5:0] pll_mult;
    logic [1:0] sel_low;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pll_40x <= 1'b0;
            pll_mult <= DBF_PLL_MULT_20X;
            sel_low <= DBF_SEL_LOW_8821;
        end else if (state == DBF_ST_IDLE && start_ok) begin
            pll_40x <= chk_40x;
            pll_mult <= chk_mult;
            sel_low <= chk_low;
        end
    end

    assign pll_40x_o = pll_40x;
    assign pll_mult_o = pll_mult;
    assign link_format_sel_low_o = sel_low;
    assign link_format_sel_mid_o = DBF_SEL_MID;
    assign link_format_sel_high_o = DBF_SEL_HIGH;

endmodule
`default_nettype wire

// *** dv/dbf_frame_assembly_sva.sv ***
// Frame assembler checker, bound to its top
`timescale 1ns/10ps
`default_nettype none
module dbf_frame_assembly_sva (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Acknowledge
    input wire logic [15:0] chan_a_b2_quad_i, // A band 2 Q
    input wire logic [15:0] chan_b_b2_inph_i, // B band 2 I
    input wire logic frame_valid_i, // Frame offered
    input wire logic frame_ready_o, // Frame taken
    input wire logic [7:0] chan_a_lane_zero_o, // Lane A0
    input wire logic [7:0] chan_a_lane_two_o, // Lane A2
    input wire logic [7:0] chan_a_lane_three_o, // Lane A3
    input wire logic [7:0] chan_b_lane_two_o, // Lane B2
    input wire logic [7:0] lane_active_o, // Lane mask
    input wire logic octet_valid_o, // Octets valid
    input wire logic frame_start_o, // Frame start
    input wire logic pll_40x_o, // PLL at 40x
    input wire logic [5:0] pll_mult_o, // Rate numerator
    input wire logic [1:0] link_format_sel_low_o, // Mode low
    input wire logic [1:0] link_format_sel_mid_o, // Mode mid
    input wire logic [1:0] link_format_sel_high_o // Mode high
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = frame_valid_i && frame_ready_o;

    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_lane_mask: assert property (octet_valid_o |-> lane_active_o inside {8'hFF, 8'h66})
        else $error("bad lane mask");
    chk_unused_quiet: assert property ((lane_active_o == 8'h66 || !octet_valid_o) |->
        chan_a_lane_zero_o == 8'h00 && chan_a_lane_three_o == 8'h00)
        else $error("unused lane busy");
    chk_pll_match: assert property (pll_mult_o == (pll_40x_o ? 6'h28 : 6'h14) &&
        link_format_sel_low_o == (pll_40x_o ? 2'h2 : 2'h1))
        else $error("pll and mode mismatch");
    chk_sel_zero: assert property (link_format_sel_mid_o == 2'h0 && link_format_sel_high_o == 2'h0)
        else $error("mode mid or high set");
    chk_start_hi: assert property (take |-> ##2 frame_start_o && octet_valid_o &&
        chan_b_lane_two_o == $past(chan_b_b2_inph_i[15:8], 2))
        else $error("bad first octet");
    chk_len_short: assert property (frame_start_o && !pll_40x_o |=> !frame_start_o)
        else $error("short 8-lane frame");
    chk_len_long: assert property (frame_start_o && pll_40x_o |=> (!frame_start_o) [*3])
        else $error("short 4-lane frame");
    chk_quad_late: assert property (take && pll_40x_o |-> ##4
        chan_a_lane_two_o == $past(chan_a_b2_quad_i[15:8], 4))
        else $error("bad third octet");

    cover property (take && !pll_40x_o);
    cover property (take && pll_40x_o);
    cover property (wb_ack_o);
endmodule

bind dbf_frame_assembly dbf_frame_assembly_sva u_sva (.*);
`default_nettype wire

// *** dv/dbf_rx_model.sv ***
// Receiver model: rebuilds per-lane frame words
`timescale 1ns/10ps
`default_nettype none
module dbf_rx_model (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic [63:0] lanes_i, // Lane octets, A0 lowest
    input wire logic octet_valid_i, // Octets carry samples
    input wire logic frame_start_i, // First octet of a frame
    input wire logic [2:0] frame_len_i, // Octets per frame
    output logic [255:0] words_o, // Lane words, A0 lowest
    output logic done_o // Frame complete
);
    logic [2:0] cnt;
    wire [2:0] next_cnt = frame_start_i ? 3'h1 : cnt + 3'h1;
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 3'h0;
            words_o <= '0;
        end else if (octet_valid_i) begin
            cnt <= next_cnt;
            done_o <= (next_cnt == frame_len_i);
            for (int n = 0; n < 8; n++) begin
                // Upper byte first lands high
                words_o[32*n +: 32] <= frame_start_i ? {24'h0, lanes_i[8*n +: 8]}
                    : {words_o[32*n +: 24], lanes_i[8*n +: 8]};
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/dbf_frame_assembly_tb.sv ***
// Testbench for the frame assembler
`timescale 1ns/10ps
`default_nettype none
module dbf_frame_assembly_tb;
    import dbf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, frame_valid = 1'b0, frame_ready;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0, wb_rdat;
    logic [15:0] smp [8] = '{default: 16'h0};
    logic [7:0][7:0] lane;
    logic [7:0] lane_active;
    logic octet_valid, frame_start, pll_40x, rx_done, cur_fmt = 1'b0;
    logic [5:0] pll_mult;
    logic [1:0] sel_lo, sel_mid, sel_hi;
    logic [2:0] rx_len = 3'h2;
    logic [255:0] rx_words;
    logic [255:0] exp_q [$];
    logic [5:0] decs [12] = '{DBF_DEC_8, DBF_DEC_9, DBF_DEC_10, DBF_DEC_12, DBF_DEC_16,
        DBF_DEC_18, DBF_DEC_20, DBF_DEC_24, DBF_DEC_32, 6'h00, 6'h0B, 6'h3F};
    int n_mismatch = 0, checks_done = 0, cycles = 0;

    always #2 clk_i = ~clk_i;

    dbf_frame_assembly u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .chan_a_b1_inph_i(smp[0]), .chan_a_b1_quad_i(smp[1]),
        .chan_a_b2_inph_i(smp[2]), .chan_a_b2_quad_i(smp[3]), .chan_b_b1_inph_i(smp[4]),
        .chan_b_b1_quad_i(smp[5]), .chan_b_b2_inph_i(smp[6]), .chan_b_b2_quad_i(smp[7]),
        .frame_valid_i(frame_valid), .frame_ready_o(frame_ready), .chan_a_lane_zero_o(lane[0]),
        .chan_a_lane_one_o(lane[1]), .chan_a_lane_two_o(lane[2]), .chan_a_lane_three_o(lane[3]),
        .chan_b_lane_zero_o(lane[4]), .chan_b_lane_one_o(lane[5]), .chan_b_lane_two_o(lane[6]),
        .chan_b_lane_three_o(lane[7]), .lane_active_o(lane_active), .octet_valid_o(octet_valid),
        .frame_start_o(frame_start), .pll_40x_o(pll_40x), .pll_mult_o(pll_mult),
        .link_format_sel_low_o(sel_lo), .link_format_sel_mid_o(sel_mid),
        .link_format_sel_high_o(sel_hi));

    dbf_rx_model u_rx (.clk_i(clk_i), .rst_i(rst_i), .octet_valid_i(octet_valid),
        .lanes_i(lane),
        .frame_start_i(frame_start), .frame_len_i(rx_len), .words_o(rx_words), .done_o(rx_done));

    task automatic check(input logic [255:0] got, input logic [255:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Held until ack, then one idle cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        int k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 50);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, adr, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e, input string msg);
        logic [31:0] r;
        wb_xfer(1'b0, adr, 32'h0, r);
        check(r, e, msg);
    endtask

    function automatic logic [31:0] ctrl(input logic f, input logic [5:0] dec, input logic en);
        return {18'h0, dec, 6'h0, f, en};
    endfunction

    function automatic logic exp_ok(input logic f, input logic [5:0] dec);
        return dec inside {6'h08, 6'h09, 6'h0A, 6'h0C, 6'h10, 6'h12, 6'h14}
            || f && dec inside {6'h18, 6'h20};
    endfunction

    function automatic logic [31:0] exp_mode(input logic f);
        return {18'h0, f ? 6'h28 : 6'h14, 1'b0, f, 4'h0, f ? 2'h2 : 2'h1};
    endfunction

    function automatic logic [255:0] exp_words(input logic f);
        logic [255:0] w = '0;
        for (int n = 0; n < 8; n++) w[32*n +: 32] = !f ? {16'h0, smp[n]}
            : n % 4 == 1 ? {smp[n-1], smp[n]} : n % 4 == 2 ? {smp[n], smp[n+1]} : 32'h0;
        return w;
    endfunction

    task automatic run_frames(input logic f, input int n);
        int k = 0, sent = 0;
        foreach (smp[i]) smp[i] <= 16'($urandom);
        frame_valid <= 1'b1;
        while (sent < n && k < 400) begin
            @(posedge clk_i);
            k++;
            if (frame_ready === 1'b1) begin
                exp_q.push_back(exp_words(f));
                sent++;
                foreach (smp[i]) smp[i] <= 16'($urandom);
                if (sent == n) frame_valid <= 1'b0;
            end
        end
        repeat (50) if (exp_q.size() != 0) @(posedge clk_i);
        check({sent, exp_q.size()}, {n, 32'h0}, "frame flow");
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            report_and_stop();
        end
        if (rx_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] %0t unexpected frame", $time);
            end else check(rx_words, exp_q.pop_front(), "frame words");
            check(lane_active, cur_fmt ? 8'h66 : 8'hFF, "lane mask");
        end
    end

    initial begin
        logic [5:0] dec;
        void'($urandom(32'h79A4));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(DBF_REG_CTRL, DBF_CTRL_RST, "ctrl reset");
        rd_chk(DBF_REG_STAT, 32'h1, "stat reset");
        wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0, "unmapped read");
        wr(DBF_REG_MODE, 32'h0);
        rd_chk(DBF_REG_MODE, exp_mode(1'b0), "mode read-only");
        for (int i = 0; i < 16; i++) begin
            dec = (i < 12) ? decs[i] : 6'($urandom);
            for (int f = 0; f < 2; f++) begin
                wr(DBF_REG_CTRL, ctrl(1'(f), dec, 1'b0));
                rd_chk(DBF_REG_STAT, {31'h0, exp_ok(1'(f), dec)}, "cfg ok");
                rd_chk(DBF_REG_MODE, exp_mode(1'(f)), "mode");
            end
        end
        frame_valid <= 1'b1;
        wr(DBF_REG_CTRL, ctrl(1'b0, DBF_DEC_24, 1'b1));
        rd_chk(DBF_REG_STAT, 32'h0, "refused enable");
        check({frame_ready, lane_active, octet_valid}, '0, "idle lanes");
        frame_valid <= 1'b0;
        for (int f = 0; f < 2; f++) begin
            cur_fmt <= 1'(f);
            rx_len <= f ? 3'h4 : 3'h2;
            dec = f ? DBF_DEC_32 : DBF_DEC_8;
            wr(DBF_REG_CTRL, ctrl(1'(f), dec, 1'b1));
            run_frames(1'(f), 12);
            check({pll_40x, pll_mult, sel_lo, sel_mid, sel_hi}, {1'(f), f ? 8'hA2 : 8'h51, 4'h0}, "pll");
            rd_chk(DBF_REG_STAT, f ? 32'hF : 32'h7, "underrun");
            wr(DBF_REG_STAT, 32'h4);
            rd_chk(DBF_REG_STAT, f ? 32'hB : 32'h3, "underrun clear");
            if (f == 0) rd_chk(DBF_REG_FRAMES, 32'h0000_000C, "frame count");
            wr(DBF_REG_CTRL, ctrl(1'(f), dec, 1'b0));
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
